// File: verilog/dmacc_regs.svh
// Register offsets, field positions, reset values and sizes of the DMA channel control block
`ifndef DMACC_REGS_SVH
`define DMACC_REGS_SVH
// *****************************************************
// Register offsets within one channel window
// *****************************************************
`define DMACC_CTRL_OFS    5'h00
`define DMACC_SRC_OFS     5'h04
`define DMACC_DST_OFS     5'h08
`define DMACC_RELOAD_OFS  5'h0C
`define DMACC_FWD_OFS     5'h10
`define DMACC_COUNT_OFS   5'h14
`define DMACC_CH_BIT      5
// *****************************************************
// Control register fields
// *****************************************************
`define DMACC_SEL_MSB     1
`define DMACC_SEL_LSB     0
`define DMACC_REQ_BIT     2
`define DMACC_EN_BIT      3
`define DMACC_DIR_BIT     4
// *****************************************************
// Reset values and sizes
// *****************************************************
`define DMACC_CTRL_RST    8'h00
`define DMACC_WORD_RST    16'h0000
`define DMACC_FIFO_DEPTH  8
`endif

// File: verilog/dmacc_pkg.sv
// Types shared by the DMA channel control block
package dmacc_pkg;
    // Per-channel setup written by software
    typedef struct packed {
        logic [15:0] src;     // Source pointer
        logic [15:0] dst;     // Destination pointer
        logic [15:0] reload;  // Transfer count reload
    } dmacc_cfg_type;
    // One granted transfer, as queued toward memory
    typedef struct packed {
        logic        chan;    // Channel that ran
        logic [15:0] addr;    // Forward address used
        logic [15:0] left;    // Count before this transfer
    } dmacc_desc_type;
    localparam int DMACC_DESC_W = $bits(dmacc_desc_type);
endpackage : dmacc_pkg

// File: verilog/dmacc_fifo.sv
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
module dmacc_fifo #(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];   // Storage words
    logic [AW-1:0]    wr_ptr;        // Next slot to fill
    logic [AW-1:0]    rd_ptr;        // Oldest slot
    logic [AW:0]      fill;          // Words held
    logic             push;
    logic             pop;
    assign in_ready_o  = (fill != (AW+1)'(DEPTH));
    assign out_valid_o = (fill != '0);
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;
    assign out_data_o  = mem[rd_ptr];
    // Storage write, no reset needed on data
    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr] <= in_data_i;
    end
    // Pointers and fill level
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill   <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            if (push && !pop)
                fill <= fill + 1'b1;
            else if (pop && !push)
                fill <= fill - 1'b1;
        end
    end
endmodule : dmacc_fifo

// File: verilog/dmacc_channel.sv
// One DMA channel: control flags, request flag, pointer and counter
`timescale 1ns/1ns
`include "dmacc_regs.svh"
module dmacc_channel (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wr_i,
    input  wire logic [7:0]              wdata_i,
    input  wire dmacc_pkg::dmacc_cfg_type cfg_i,
    input  wire logic [3:0]              src_i,
    input  wire logic                    grant_i,
    output logic [7:0]                   ctrl_o,
    output logic [15:0]                  fwd_o,
    output logic [15:0]                  count_o,
    output logic                         set_o
);
    import dmacc_pkg::*;
    logic [1:0] sel;       // Request source select
    logic       req;       // Pending request flag
    logic       en;        // Channel enable
    logic       dir;       // 1: destination steps forward
    logic       src_prev;  // Selected source, last cycle
    logic       src_now;
    logic       next_req;
    assign src_now = src_i[sel];
    // Rising request edge, or a changed select field
    assign set_o = (src_now && !src_prev) || // [R6]
                   (wr_i && wdata_i[`DMACC_SEL_MSB:`DMACC_SEL_LSB] != sel); // [R9]
    // Set wins over both clears
    always_comb
    begin
        next_req = req;
        if (grant_i)
            next_req = 1'b0; // [R7]
        if (wr_i && !wdata_i[`DMACC_REQ_BIT])
            next_req = 1'b0; // [R8]
        if (set_o)
            next_req = 1'b1; // [R6]
    end
    // Source history and request flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            src_prev <= 1'b0;
            req      <= 1'b0;
        end
        else
        begin
            src_prev <= src_now;
            req      <= next_req;
        end
    end
    // Enable, direction and select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            {dir, en, sel} <= 4'h0;
        else if (wr_i)
        begin
            sel <= wdata_i[`DMACC_SEL_MSB:`DMACC_SEL_LSB];
            en  <= wdata_i[`DMACC_EN_BIT]; // [R1]
            dir <= wdata_i[`DMACC_DIR_BIT];
        end
        else if (grant_i && count_o <= 16'h0001)
            en <= 1'b0;   // Last transfer ends the run
    end
    // Pointer and counter: an enable write always restarts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            fwd_o   <= `DMACC_WORD_RST;
            count_o <= `DMACC_WORD_RST;
        end
        else if (wr_i && wdata_i[`DMACC_EN_BIT])
        begin
            fwd_o   <= wdata_i[`DMACC_DIR_BIT] ? cfg_i.dst : cfg_i.src; // [R2] [R4]
            count_o <= cfg_i.reload; // [R3] [R4]
        end
        else if (grant_i)
        begin
            fwd_o   <= fwd_o + 16'h0001;
            count_o <= count_o - 16'h0001;
        end
    end
    assign ctrl_o = {3'h0, dir, en, req, sel}; // [R5]
endmodule : dmacc_channel

// File: verilog/dmacc_top.sv
// Two-channel DMA control with a Wishbone register slave and a transfer queue
// Behaviour
// R1: Enable flag sits in control bit 3
// R2: Enable write loads forward pointer from chosen
// R3: Enable write copies reload into transfer counter
// R4: Re-enabling an active channel restarts from scratch
// R5: Request flag sits in control bit 2
// R6: Source request sets flag, enabled or not
// R7: Flag clears when its transfer begins
// R8: Software writes 0 to clear, 1 ignored
// R9: Changing source select may set the flag
// R10: Software clears flag after changing select
// R11: Enabled channel starts transfer on flag at once
// R12: Software judges activity by enable, not request
// R13: Pending flag starts transfer once channel enabled
`timescale 1ns/1ns
`include "dmacc_regs.svh"
module dmacc_top (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [7:0]           adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [31:0]          dat_i,
    output logic [31:0]               dat_o,
    output logic                      ack_o,
    input  wire logic [3:0]           chan0_src_i,
    input  wire logic [3:0]           chan1_src_i,
    output logic                      xfer_valid_o,
    input  wire logic                 xfer_ready_i,
    output dmacc_pkg::dmacc_desc_type xfer_o
);
    import dmacc_pkg::*;
    // *****************************************************
    // Declarations
    // *****************************************************
    dmacc_cfg_type  cfg [2];      // Software setup per channel
    logic [7:0]     ctrl [2];     // Control view per channel
    logic [15:0]    fwd [2];      // Working forward pointers
    logic [15:0]    count [2];    // Working counters
    logic [1:0]     set;          // Request flag set pulses
    logic [1:0]     wr_ctrl;      // Control write strobes
    logic [1:0]     want;         // Enabled and pending
    logic [1:0]     grant;        // Transfer begins now
    logic [3:0]     src [2];      // Request lines per channel
    logic           bus_req;      // Valid Wishbone cycle
    logic           bus_wr;       // Write taking effect
    logic           mapped;       // Address inside the map
    logic           ch;           // Addressed channel
    logic [4:0]     ofs;          // Offset within window
    logic [15:0]    lane_mask;    // Write lanes from sel
    logic [31:0]    next_dat;     // Read data being formed
    logic           q_ready;      // Queue has room
    dmacc_desc_type q_in;         // Descriptor to queue
    assign src[0] = chan0_src_i;
    assign src[1] = chan1_src_i;
    // *****************************************************
    // Wishbone decode
    // *****************************************************
    // Request seen when both strobes are high
    assign bus_req   = cyc_i && stb_i;
    // Writes land on the edge that sees ack high
    assign bus_wr    = bus_req && we_i && ack_o;
    // Upper address bits must be zero to hit a register
    assign mapped    = (adr_i[7:6] == 2'h0);
    assign ch        = adr_i[`DMACC_CH_BIT];
    assign ofs       = {adr_i[4:2], 2'h0};
    assign lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
    // Byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge
    // Ack one cycle after the request, dropped the cycle after
    // Unmapped addresses are still acked, reading zero, so the master never hangs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= bus_req && !ack_o;
    end
    // *****************************************************
    // Setup registers
    // *****************************************************
    // Pointers and reload count, byte-lane writable
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cfg[0] <= '0;
            cfg[1] <= '0;
        end
        else if (bus_wr && mapped)
        begin
            unique case (ofs)
                `DMACC_SRC_OFS:
                    cfg[ch].src <= merge(cfg[ch].src, dat_i[15:0], lane_mask);
                `DMACC_DST_OFS:
                    cfg[ch].dst <= merge(cfg[ch].dst, dat_i[15:0], lane_mask);
                `DMACC_RELOAD_OFS:
                    cfg[ch].reload <= merge(cfg[ch].reload, dat_i[15:0], lane_mask);
                default:
                    ;   // Other offsets hold no setup
            endcase
        end
    end
    // Control writes need the low byte lane
    assign wr_ctrl[0] = bus_wr && mapped && !ch && ofs == `DMACC_CTRL_OFS && sel_i[0];
    assign wr_ctrl[1] = bus_wr && mapped && ch && ofs == `DMACC_CTRL_OFS && sel_i[0];
    // *****************************************************
    // Channels and arbitration
    // *****************************************************
    // A pending flag waits while disabled and runs on enable
    assign want[0] = ctrl[0][`DMACC_EN_BIT] && ctrl[0][`DMACC_REQ_BIT]; // [R13]
    assign want[1] = ctrl[1][`DMACC_EN_BIT] && ctrl[1][`DMACC_REQ_BIT]; // [R13]
    // Start at once when room; channel zero wins a tie
    // A full queue holds the flag pending instead of losing it
    assign grant[0] = want[0] && q_ready; // [R11]
    assign grant[1] = want[1] && !want[0] && q_ready; // [R11]
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_chan
            // One control engine per channel
            dmacc_channel u_chan (
                .clk_i   (clk_i),
                .rst_i   (rst_i),
                .wr_i    (wr_ctrl[gi]),
                .wdata_i (dat_i[7:0]),
                .cfg_i   (cfg[gi]),
                .src_i   (src[gi]),
                .grant_i (grant[gi]),
                .ctrl_o  (ctrl[gi]),
                .fwd_o   (fwd[gi]),
                .count_o (count[gi]),
                .set_o   (set[gi])
            );
        end
    endgenerate
    // *****************************************************
    // Transfer queue
    // *****************************************************
    // Descriptor of the granted channel
    always_comb
    begin
        q_in      = '0;
        q_in.chan = grant[1];
        q_in.addr = grant[1] ? fwd[1] : fwd[0];
        q_in.left = grant[1] ? count[1] : count[0];
    end
    // Queue toward memory; downstream stalls fill it
    dmacc_fifo #(
        .WIDTH (DMACC_DESC_W),
        .DEPTH (`DMACC_FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (|grant),
        .in_ready_o  (q_ready),
        .in_data_i   (q_in),
        .out_valid_o (xfer_valid_o),
        .out_ready_i (xfer_ready_i),
        .out_data_o  (xfer_o)
    );
    // *****************************************************
    // Read data
    // *****************************************************
    // Enable bit is the reliable activity view, request clears too fast
    always_comb
    begin
        next_dat = 32'h0000_0000;
        if (mapped)
        begin
            unique case (ofs)
                `DMACC_CTRL_OFS:   next_dat = {24'h00_0000, ctrl[ch]};
                `DMACC_SRC_OFS:    next_dat = {16'h0000, cfg[ch].src};
                `DMACC_DST_OFS:    next_dat = {16'h0000, cfg[ch].dst};
                `DMACC_RELOAD_OFS: next_dat = {16'h0000, cfg[ch].reload};
                `DMACC_FWD_OFS:    next_dat = {16'h0000, fwd[ch]};
                `DMACC_COUNT_OFS:  next_dat = {16'h0000, count[ch]};
                default:           next_dat = 32'h0000_0000;
            endcase
        end
    end
    // Captured with ack and held while it stands
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (bus_req && !ack_o)
            dat_o <= next_dat;
    end
    // *****************************************************
    // Checks
    // *****************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Enable write shows in bit 3 next cycle
    chk_enable_bit_set: assert property ( // [R1]
        wr_ctrl[0] && dat_i[3] |=> ctrl[0][3])
        else $error("enable bit not set by write");
    // Forward pointer loaded from the chosen pointer
    chk_fwd_load_dir: assert property ( // [R2]
        wr_ctrl[0] && dat_i[`DMACC_EN_BIT] |=>
        fwd[0] == ($past(dat_i[4]) ? $past(cfg[0].dst) : $past(cfg[0].src)))
        else $error("forward pointer not reloaded");
    // Counter takes the reload value
    chk_count_reload: assert property ( // [R3]
        wr_ctrl[1] && dat_i[`DMACC_EN_BIT] |=> count[1] == $past(cfg[1].reload))
        else $error("counter not reloaded");
    // Active channel restarts on enable write
    chk_active_restart: assert property ( // [R4]
        ctrl[0][3] && wr_ctrl[0] && dat_i[3] |=>
        count[0] == $past(cfg[0].reload) && ctrl[0][3])
        else $error("active channel did not restart");
    // Request lands in bit 2 even while disabled
    chk_request_sets: assert property ( // [R5] [R6]
        set[1] |=> ctrl[1][2])
        else $error("request flag not set");
    // Grant clears the flag unless a new request arrived
    chk_grant_clears: assert property ( // [R7]
        grant[0] && !set[0] |=> !ctrl[0][2])
        else $error("request flag not cleared on transfer");
    // Software write of one never sets the flag
    chk_sw_no_set: assert property ( // [R8]
        !ctrl[0][2] && !set[0] ##0 wr_ctrl[0] |=> !ctrl[0][2])
        else $error("software set the request flag");
    // Software write of zero clears it
    chk_sw_clear: assert property ( // [R8]
        wr_ctrl[1] && !dat_i[2] && !set[1] |=> !ctrl[1][2])
        else $error("request flag not cleared by software");
    // New select value raises the flag
    chk_select_sets: assert property ( // [R9]
        wr_ctrl[0] && dat_i[1:0] != ctrl[0][1:0] |=> ctrl[0][2])
        else $error("select change did not set flag");
    // Enabled pending channel with room is granted now
    chk_start_at_once: assert property ( // [R11]
        want[0] && q_ready |-> grant[0] ##1 (!ctrl[0][2] || $past(set[0])))
        else $error("enabled request not started");
    // Pending disabled flag runs in the first cycle the enable shows
    chk_pending_runs: assert property ( // [R13]
        ctrl[1][2] && !ctrl[1][3] && !want[0] && q_ready ##1
        ctrl[1][2] && ctrl[1][3] && !want[0] && q_ready
        |-> grant[1])
        else $error("pending request lost on enable");
    // Bus answers exactly one cycle after request
    chk_bus_ack: assert property (
        bus_req && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack timing wrong");
    // A granted transfer on channel one steps its pointer by one
    chk_fwd_step: assert property (
        grant[1] && !wr_ctrl[1] |=> fwd[1] == $past(fwd[1]) + 16'h0001)
        else $error("forward pointer did not step");
    // Last transfer of a run drops the enable
    chk_run_done: assert property (
        grant[0] && !wr_ctrl[0] && count[0] == 16'h0001 |=> !ctrl[0][3])
        else $error("run did not end on last transfer");
    cov_restart: cover property (ctrl[0][3] && wr_ctrl[0] && dat_i[3]);
    cov_both_want: cover property (want[0] && want[1]);
    cov_queue_full: cover property (want[0] && !q_ready);
    cov_pending_enable: cover property (ctrl[1][2] && !ctrl[1][3] ##1 grant[1]);
endmodule : dmacc_top

// File: tb/dmacc_sink.sv
// Behavioural model of the transfer consumer that sits behind the descriptor queue
`timescale 1ns/1ns
module dmacc_sink
    import dmacc_pkg::*;
(
    input  wire logic           clk_i,
    input  wire logic           rst_i,
    input  wire logic           xfer_valid_i,
    input  wire dmacc_desc_type xfer_i,
    input  wire logic           stall_i,
    output logic                xfer_ready_o
);
    // *****************************************************
    // Acceptance and capture
    // *****************************************************
    dmacc_desc_type got[$];  // Descriptors taken, oldest first

    // Stall lets the bench hold the queue full; no stall answers at once
    assign xfer_ready_o = !stall_i;

    // Capture only on a real handshake, never while reset holds the block
    always @(posedge clk_i)
    begin
        if (!rst_i && xfer_valid_i === 1'b1 && xfer_ready_o)
        begin
            got.push_back(xfer_i);
        end
    end
endmodule : dmacc_sink

// File: tb/tb_dmacc_top.sv
// Self-checking bench for the two-channel DMA control block
`timescale 1ns/1ns
module tb_dmacc_top;
    import dmacc_pkg::*;
    // Bus step of the register table: write, or read with expected data
    typedef struct {logic we; logic [7:0] adr; logic [31:0] dat;} dmacc_row_type;
    logic           clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, xfer_valid_o, xfer_ready_i, stall;
    logic [7:0]     adr_i;
    logic [3:0]     sel_i, chan0_src_i, chan1_src_i;
    logic [31:0]    dat_i, dat_o, rd;
    dmacc_desc_type xfer_o;
    int             err_total, check_count, cycles, i;
    // Setup rows: pointers, reload, unmapped places, then arm channel zero
    dmacc_row_type rows [16] = '{
        '{1'b1, 8'h04, 32'hFFFF1234}, '{1'b1, 8'h08, 32'h00005678}, '{1'b1, 8'h0C, 32'h00000003},
        '{1'b0, 8'h04, 32'h00001234}, '{1'b0, 8'h0C, 32'h00000003}, '{1'b1, 8'h24, 32'h0000ABCD},
        '{1'b1, 8'h2C, 32'h00000001}, '{1'b0, 8'h24, 32'h0000ABCD}, '{1'b1, 8'h18, 32'h0000FFFF},
        '{1'b0, 8'h18, 32'h00000000}, '{1'b1, 8'h40, 32'h0000FFFF}, '{1'b0, 8'h40, 32'h00000000},
        '{1'b1, 8'h00, 32'h00000018}, '{1'b0, 8'h00, 32'h00000018}, '{1'b0, 8'h10, 32'h00005678},
        '{1'b0, 8'h14, 32'h00000003}};

    dmacc_top dmacc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .chan0_src_i(chan0_src_i), .chan1_src_i(chan1_src_i), .xfer_valid_o(xfer_valid_o),
        .xfer_ready_i(xfer_ready_i), .xfer_o(xfer_o));
    dmacc_sink dmacc_sink_inst (.clk_i(clk_i), .rst_i(rst_i), .xfer_valid_i(xfer_valid_o), .xfer_i(xfer_o),
        .stall_i(stall), .xfer_ready_o(xfer_ready_i));

    // *****************************************************
    // Clock and hang guard
    // *****************************************************
    // 100 ns period
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Whole run is a few hundred cycles; the ceiling leaves ample margin
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_total++;
            $display("MISMATCH run_length expected finish seen hang");
            tally_and_finish();
        end
    end

    // *****************************************************
    // Shared tasks
    // *****************************************************
    // Compare up to a full descriptor; case inequality so X never matches
    task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Classic single cycle: hold all until ack sampled high, then release
    // No cycle limit here: only the run timeout ends a wait for ack
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= we; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        rd = dat_o;
        cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0);
        chk(nm, {1'b0, e}, {1'b0, rd});
    endtask : rchk
    // One rising edge on line 0 of a channel's request sources
    task automatic pulse(input int ch);
        @(posedge clk_i);
        if (ch == 0) chan0_src_i <= 4'h1; else chan1_src_i <= 4'h1;
        @(posedge clk_i);
        chan0_src_i <= 4'h0; chan1_src_i <= 4'h0;
        @(posedge clk_i);
    endtask : pulse
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // *****************************************************
    // Main sequence
    // *****************************************************
    initial
    begin
        rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 8'h00; sel_i = 4'h0;
        dat_i = 32'h0; chan0_src_i = 4'h0; chan1_src_i = 4'h0; stall = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        // Reset values of control, counter and queue
        rchk(8'h00, 32'h0, "ctrl0_reset");
        rchk(8'h14, 32'h0, "count0_reset");
        chk("valid_reset", 33'h0, {32'h0, xfer_valid_o});
        $display("test reset done");
        // Table rows; arming write reloads pointer and counter
        for (i = 0; i < 16; i++)
        begin
            wb(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) chk("table_read", {1'b0, rows[i].dat}, {1'b0, rd});
        end
        $display("test table done");
        // Enabled channel: request becomes a transfer at once
        pulse(0);
        repeat (3) @(posedge clk_i);
        chk("desc_count", 33'h1, {1'b0, 32'(dmacc_sink_inst.got.size())});
        chk("desc0", {1'b0, 16'h5678, 16'h0003}, dmacc_sink_inst.got[0]);
        rchk(8'h00, 32'h18, "ctrl0_req_clear");
        rchk(8'h10, 32'h5679, "fwd0_step");
        dmacc_sink_inst.got.delete();
        // Re-arming an active channel discards progress
        wb(1'b1, 8'h00, 32'h18);
        rchk(8'h10, 32'h5678, "fwd0_restart");
        rchk(8'h14, 32'h0003, "count0_restart");
        $display("test grant and restart done");
        // Disabled channel keeps its flag; only a written 0 clears it
        pulse(1);
        rchk(8'h20, 32'h04, "ctrl1_pending");
        wb(1'b1, 8'h20, 32'h04);
        rchk(8'h20, 32'h04, "ctrl1_write_one");
        wb(1'b1, 8'h20, 32'h00);
        rchk(8'h20, 32'h00, "ctrl1_write_zero");
        pulse(1);
        wb(1'b1, 8'h20, 32'h0C);
        repeat (3) @(posedge clk_i);
        chk("desc1", {1'b1, 16'hABCD, 16'h0001}, dmacc_sink_inst.got[0]);
        rchk(8'h20, 32'h00, "ctrl1_run_done");
        rchk(8'h30, 32'hABCE, "fwd1_step");
        dmacc_sink_inst.got.delete();
        // New select raises the flag; software then clears it
        wb(1'b1, 8'h20, 32'h05);
        rchk(8'h20, 32'h05, "ctrl1_select");
        wb(1'b1, 8'h20, 32'h01);
        rchk(8'h20, 32'h01, "ctrl1_select_clr");
        $display("test pending and select done");
        // Queue filled while the consumer stalls, then drained
        stall <= 1'b1;
        wb(1'b1, 8'h0C, 32'h000A);
        wb(1'b1, 8'h00, 32'h18);
        repeat (9) pulse(0);
        chk("valid_full", 33'h1, {32'h0, xfer_valid_o});
        rchk(8'h14, 32'h0002, "count0_full");
        rchk(8'h00, 32'h1C, "ctrl0_held");
        stall <= 1'b0;
        repeat (20) @(posedge clk_i);
        chk("drain_count", 33'h9, {1'b0, 32'(dmacc_sink_inst.got.size())});
        for (i = 0; i < 9 && i < dmacc_sink_inst.got.size(); i++)
            chk("drain_desc", {1'b0, 16'(16'h5678 + i), 16'(16'h000A - i)}, dmacc_sink_inst.got[i]);
        rchk(8'h14, 32'h0001, "count0_drained");
        $display("test queue fill done");
        // Reset in mid-run empties a held queue and clears channel state
        stall <= 1'b1;
        pulse(0);
        @(posedge clk_i);
        chk("valid_held", 33'h1, {32'h0, xfer_valid_o});
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        stall <= 1'b0;
        @(posedge clk_i);
        chk("valid_mid_reset", 33'h0, {32'h0, xfer_valid_o});
        rchk(8'h00, 32'h0, "ctrl0_mid_reset");
        rchk(8'h10, 32'h0, "fwd0_mid_reset");
        $display("test mid reset done");
        tally_and_finish();
    end
endmodule : tb_dmacc_top
